/* src/ste_params.svh */
// offsets, field positions, reset values and timing counts of the thermal event control
`ifndef STE_PARAMS_SVH
`define STE_PARAMS_SVH

`define STE_ADDR_CFG 8'h00
`define STE_ADDR_HIGH 8'h04
`define STE_ADDR_LOW 8'h08
`define STE_ADDR_CRIT 8'h0c
`define STE_ADDR_TEMP 8'h10
`define STE_ADDR_STATUS 8'h14
`define STE_ADDR_CMD 8'h18
`define STE_ADDR_PROT 8'h1c
`define STE_ADDR_ACC 8'h20

`define STE_CFG_RST 6'h00
`define STE_LIMIT_RST 13'h0000
`define STE_CLEAR_EVENT_BIT 0
`define STE_CMD_W 11
`define STE_TEMP_W 13
`define STE_SYNC_W 18

`define STE_HYST_0 14'h0000
`define STE_HYST_1 14'h0018
`define STE_HYST_2 14'h0030
`define STE_HYST_3 14'h0060

`define STE_CLK_MHZ 100
`define STE_SAMPLE_MS 125
`define STE_SAMPLE_CYC (`STE_SAMPLE_MS * 1000 * `STE_CLK_MHZ)

`endif

/* src/ste_pkg.sv */
// types shared by the thermal event control files
package ste_pkg;

  typedef struct packed {
    logic [1:0] hyst;
    logic event_en;
    logic pol_high;
    logic crit_only;
    logic cmp_mode;
  } ste_cfg_t;

  typedef enum logic [1:0] {
    STE_OP_NONE = 2'h0,
    STE_OP_SET = 2'h1,
    STE_OP_CLR = 2'h2,
    STE_OP_PAGE = 2'h3
  } ste_op_t;

  typedef struct packed {
    logic [1:0] blk;
    ste_op_t op;
    logic [6:0] addr;
  } ste_cmd_t;

  typedef enum logic [2:0] {
    STE_CS_IDLE = 3'b001,
    STE_CS_WAIT = 3'b010,
    STE_CS_EXEC = 3'b100
  } ste_cst_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } ste_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } ste_apb_rsp_t;

endpackage : ste_pkg

/* src/ste_sync2.sv */
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module ste_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : ste_sync2

/* src/ste_event_ctrl.sv */
// thermal event alert, select-address match and eeprom block protection control
`timescale 1ns/1ps
`include "ste_params.svh"
module ste_event_ctrl #(
  parameter int unsigned SAMPLE_CYC = `STE_SAMPLE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input ste_pkg::ste_apb_req_t apb_req,
  output ste_pkg::ste_apb_rsp_t apb_rsp,
  input wire logic select_input_zero,
  input wire logic select_input_one,
  input wire logic select_input_two,
  input wire logic high_voltage_level,
  input wire logic scl,
  input wire logic [12:0] adc_temp,
  output logic event_pin_out,
  output logic event_pin_oe,
  output logic [3:0] block_lock,
  output logic page_sel
);
  import ste_pkg::*;

  logic [`STE_SYNC_W-1:0] pin_raw, pin_syn;
  logic [2:0] logical_bus_address_bits;
  logic [12:0] adc_s;
  logic hv_s, scl_s, scl_prev_q, scl_rise;
  ste_apb_rsp_t rsp_q;
  logic [31:0] rd_d;
  logic hit_d, acc, done, wr;
  ste_cfg_t cfg_q;
  logic [12:0] high_q, low_q, critical_threshold_q, temp_q;
  logic [23:0] cnt_q;
  logic tick;
  logic signed [13:0] t_s, hi_s, lo_s, ct_s, hy_s;
  logic win_set, win_rel, clear_ev, asserted;
  logic crit_flag_q, win_flag_q, win_prev_q, int_q, event_pin_oe_q;
  ste_cst_t st_q;
  ste_cmd_t cmd_q;
  logic [3:0] prot_q;
  logic [8:0] acc_phys_q;
  logic hv_q, addr_match, page_q, refused_q, acc_lock_q;

  default clocking dcb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // pins come from outside the pclk domain
  assign pin_raw = {select_input_two, select_input_one, select_input_zero,
                    high_voltage_level, scl, adc_temp};

  ste_sync2 #(
    .WIDTH(`STE_SYNC_W)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(pin_raw),
    .q(pin_syn)
  );

  assign logical_bus_address_bits = pin_syn[17:15];
  assign hv_s = pin_syn[14];
  assign scl_s = pin_syn[13];
  assign adc_s = pin_syn[12:0];
  assign scl_rise = scl_s & ~scl_prev_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_prev_q <= 1'b0;
    end else begin
      scl_prev_q <= scl_s;
    end
  end

  // apb slave: one wait state, answer registered
  assign acc = apb_req.psel & apb_req.penable;
  assign done = acc & rsp_q.pready;
  assign wr = done & apb_req.pwrite;
  assign apb_rsp = rsp_q;

  always_comb begin
    rd_d = 32'h0000_0000;
    hit_d = 1'b1;
    case (apb_req.paddr)
      `STE_ADDR_CFG: rd_d = 32'(cfg_q);
      `STE_ADDR_HIGH: rd_d = 32'(high_q);
      `STE_ADDR_LOW: rd_d = 32'(low_q);
      `STE_ADDR_CRIT: rd_d = 32'(critical_threshold_q);
      `STE_ADDR_TEMP: rd_d = 32'(temp_q);
      `STE_ADDR_STATUS: rd_d = 32'({crit_flag_q, win_flag_q, int_q, event_pin_oe_q});
      `STE_ADDR_CMD: rd_d = 32'(cmd_q);
      `STE_ADDR_PROT: rd_d = 32'({refused_q, st_q != STE_CS_IDLE, page_q, prot_q});
      `STE_ADDR_ACC: rd_d = 32'({acc_lock_q, acc_phys_q});
      default: hit_d = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsp_q <= '0;
    end else begin
      rsp_q.pready <= acc & ~rsp_q.pready;
      if (acc & ~rsp_q.pready) begin
        rsp_q.prdata <= apb_req.pwrite ? 32'h0000_0000 : rd_d;
        rsp_q.pslverr <= ~hit_d;
      end
    end
  end

  // configuration and limits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= `STE_CFG_RST;
      high_q <= `STE_LIMIT_RST;
      low_q <= `STE_LIMIT_RST;
      critical_threshold_q <= `STE_LIMIT_RST;
    end else if (wr) begin
      case (apb_req.paddr)
        `STE_ADDR_CFG: cfg_q <= apb_req.pwdata[5:0];
        `STE_ADDR_HIGH: high_q <= apb_req.pwdata[12:0];
        `STE_ADDR_LOW: low_q <= apb_req.pwdata[12:0];
        `STE_ADDR_CRIT: critical_threshold_q <= apb_req.pwdata[12:0];
        default: ;
      endcase
    end
  end

  // conversion tick; adc bus must be stable around each tick
  assign tick = (cnt_q == 24'(SAMPLE_CYC - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 24'h00_0000;
      temp_q <= `STE_LIMIT_RST;
    end else begin
      cnt_q <= tick ? 24'h00_0000 : cnt_q + 24'h00_0001;
      if (tick) begin
        temp_q <= adc_s;
      end
    end
  end

  // comparisons on sign-extended values so hysteresis cannot wrap
  assign t_s = $signed({temp_q[12], temp_q});
  assign hi_s = $signed({high_q[12], high_q});
  assign lo_s = $signed({low_q[12], low_q});
  assign ct_s = $signed({critical_threshold_q[12], critical_threshold_q});

  always_comb begin
    case (cfg_q.hyst)
      2'h0: hy_s = `STE_HYST_0;
      2'h1: hy_s = `STE_HYST_1;
      2'h2: hy_s = `STE_HYST_2;
      default: hy_s = `STE_HYST_3;
    endcase
  end

  assign win_set = (t_s > hi_s) | (t_s < lo_s);
  assign win_rel = (t_s <= hi_s - hy_s) & (t_s >= lo_s + hy_s);
  assign clear_ev = wr & (apb_req.paddr == `STE_ADDR_STATUS) &
                    apb_req.pwdata[`STE_CLEAR_EVENT_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crit_flag_q <= 1'b0;
    end else if (t_s > ct_s) begin
      crit_flag_q <= 1'b1;
    end else if (t_s < ct_s - hy_s) begin
      crit_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_flag_q <= 1'b0;
      win_prev_q <= 1'b0;
    end else begin
      win_prev_q <= win_flag_q;
      if (win_set) begin
        win_flag_q <= 1'b1;
      end else if (win_rel) begin
        win_flag_q <= 1'b0;
      end
    end
  end

  // a new event in the clearing cycle keeps the latch set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_q <= 1'b0;
    end else if (win_flag_q & ~win_prev_q) begin
      int_q <= 1'b1;
    end else if (clear_ev) begin
      int_q <= 1'b0;
    end
  end

  always_comb begin
    if (!cfg_q.event_en) begin
      asserted = 1'b0;
    end else if (cfg_q.crit_only) begin
      asserted = crit_flag_q;
    end else begin
      asserted = crit_flag_q | (cfg_q.cmp_mode ? win_flag_q : int_q);
    end
  end

  // open drain: only ever pulls low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_pin_oe_q <= 1'b0;
      event_pin_out <= 1'b0;
    end else begin
      event_pin_oe_q <= cfg_q.pol_high ? ~asserted : asserted;
      event_pin_out <= 1'b0;
    end
  end

  assign event_pin_oe = event_pin_oe_q;

  // commands run at the next serial clock rise, when the high voltage level is sampled
  assign addr_match = (cmd_q.addr[3:1] == logical_bus_address_bits);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= STE_CS_IDLE;
      cmd_q <= '0;
      hv_q <= 1'b0;
    end else begin
      case (st_q)
        STE_CS_IDLE: begin
          if (wr & (apb_req.paddr == `STE_ADDR_CMD)) begin
            cmd_q <= apb_req.pwdata[`STE_CMD_W-1:0];
            st_q <= STE_CS_WAIT;
          end
        end
        STE_CS_WAIT: begin
          if (scl_rise) begin
            hv_q <= hv_s;
            st_q <= STE_CS_EXEC;
          end
        end
        STE_CS_EXEC: st_q <= STE_CS_IDLE;
        default: st_q <= STE_CS_IDLE;
      endcase
    end
  end

  // locks live in flops only, so a clear with high voltage and a matching address undoes them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prot_q <= 4'h0;
      page_q <= 1'b0;
      refused_q <= 1'b0;
    end else if (st_q == STE_CS_EXEC) begin
      refused_q <= ~addr_match;
      if (addr_match) begin
        case (cmd_q.op)
          STE_OP_SET: begin
            if (hv_q) begin
              prot_q[cmd_q.blk] <= 1'b1;
            end else begin
              refused_q <= 1'b1;
            end
          end
          STE_OP_CLR: begin
            if (hv_q) begin
              prot_q <= 4'h0;
            end else begin
              refused_q <= 1'b1;
            end
          end
          STE_OP_PAGE: page_q <= cmd_q.blk[0];
          default: ;
        endcase
      end
    end
  end

  assign block_lock = prot_q;
  assign page_sel = page_q;

  // legacy 8-bit offset mapped onto the selected page
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_phys_q <= 9'h000;
      acc_lock_q <= 1'b0;
    end else if (wr & (apb_req.paddr == `STE_ADDR_ACC)) begin
      acc_phys_q <= {page_q, apb_req.pwdata[7:0]};
      acc_lock_q <= prot_q[{page_q, apb_req.pwdata[7]}];
    end
  end

  property p_addr_match;
    (st_q == STE_CS_EXEC && !addr_match) |=> $stable(prot_q) && $stable(page_q);
  endproperty
  a_addr_match: assert property (p_addr_match) else $error("lock changed on mismatch");
  property p_hv_needed;
    (st_q == STE_CS_EXEC && cmd_q.op == STE_OP_SET && !hv_q) |=> $stable(prot_q) && refused_q;
  endproperty
  a_hv_needed: assert property (p_hv_needed) else $error("lock set without hv");
  property p_clear_event;
    (clear_ev && !(win_flag_q && !win_prev_q)) |=> !int_q;
  endproperty
  a_clear_event: assert property (p_clear_event) else $error("event not cleared");
  property p_cmp_release;
    (cfg_q.event_en && !cfg_q.pol_high && !cfg_q.crit_only && cfg_q.cmp_mode &&
     !win_flag_q && !crit_flag_q) |=> !event_pin_oe;
  endproperty
  a_cmp_release: assert property (p_cmp_release) else $error("comparator held");
  property p_crit_set;
    (cfg_q.event_en && !cfg_q.pol_high && crit_flag_q) |=> event_pin_oe;
  endproperty
  a_crit_set: assert property (p_crit_set) else $error("critical alert missing");
  property p_crit_only;
    (cfg_q.event_en && cfg_q.crit_only && !cfg_q.pol_high && !crit_flag_q) |=> !event_pin_oe;
  endproperty
  a_crit_only: assert property (p_crit_only) else $error("limit alert in crit-only");
  property p_crit_hold;
    (crit_flag_q && t_s >= ct_s - hy_s) |=> crit_flag_q;
  endproperty
  a_crit_hold: assert property (p_crit_hold) else $error("critical released early");
  property p_pol_high_rest;
    (cfg_q.pol_high && !asserted) |=> event_pin_oe;
  endproperty
  a_pol_high_rest: assert property (p_pol_high_rest) else $error("idle not driven low");
  property p_clear_all;
    (st_q == STE_CS_EXEC && addr_match && cmd_q.op == STE_OP_CLR && hv_q) |=> prot_q == 4'h0;
  endproperty
  a_clear_all: assert property (p_clear_all) else $error("locks not cleared");
  property p_sample_rate;
    cnt_q < 24'(SAMPLE_CYC);
  endproperty
  a_sample_rate: assert property (p_sample_rate) else $error("sample period overrun");
  property p_latch;
    tick |=> temp_q == $past(adc_s) ##1 $stable(temp_q);
  endproperty
  a_latch: assert property (p_latch) else $error("temperature not latched");
  property p_open_drain;
    event_pin_oe |-> event_pin_out == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("alert driven high");

endmodule : ste_event_ctrl

/* testbench/ste_host_model.sv */
// host-side pin model: address selects, high voltage, serial clock, alert sense
`timescale 1ns/1ps
module ste_host_model (
  input wire logic pclk,
  input wire logic event_pin_oe,
  output logic select_input_zero,
  output logic select_input_one,
  output logic select_input_two,
  output logic high_voltage_level,
  output logic scl,
  output logic pin_level
);
  // board pull-up on the open-drain alert line
  assign pin_level = event_pin_oe ? 1'b0 : 1'b1;
  initial begin
    select_input_zero = 1'b0;
    select_input_one = 1'b0;
    select_input_two = 1'b0;
    high_voltage_level = 1'b0;
    scl = 1'b1;
  end
  // high voltage rides on select zero, so that pin also reads high
  task automatic set_pins(input logic [2:0] sel, input logic hv);
    @(posedge pclk);
    select_input_zero <= sel[0] | hv;
    select_input_one <= sel[1];
    select_input_two <= sel[2];
    high_voltage_level <= hv;
  endtask : set_pins
  // one 160 ns serial clock period; line idles high between frames
  task automatic frame();
    #3 scl = 1'b0;
    #80 scl = 1'b1;
    #80;
  endtask : frame
endmodule : ste_host_model

/* testbench/tb_top.sv */
// self-checking bench for the thermal event control
`timescale 1ns/1ps
`include "ste_params.svh"
module tb_top;
  import ste_pkg::*;
  localparam int SC = 20;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  ste_apb_req_t req = '0;
  ste_apb_rsp_t rsp;
  logic [12:0] adc_temp = 13'h0000;
  logic s0, s1, s2, hv, scl, oe, pout, pin, page_sel, er;
  logic [3:0] block_lock;
  logic [31:0] rd;
  logic [31:0] seed = 32'h1254;
  logic [3:0] lk_e = 4'h0;
  logic pg_e = 1'b0;
  logic [2:0] sel = 3'h0;
  int errors = 0;
  int n_checks = 0;
  int cyc = 0;

  ste_event_ctrl #(.SAMPLE_CYC(SC)) ste_event_ctrl_i (
    .pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .select_input_zero(s0), .select_input_one(s1), .select_input_two(s2),
    .high_voltage_level(hv), .scl(scl), .adc_temp(adc_temp), .event_pin_out(pout),
    .event_pin_oe(oe), .block_lock(block_lock), .page_sel(page_sel));

  ste_host_model ste_host_model_i (
    .pclk(pclk), .event_pin_oe(oe), .select_input_zero(s0), .select_input_one(s1),
    .select_input_two(s2), .high_voltage_level(hv), .scl(scl), .pin_level(pin));

  always #5 pclk = ~pclk;

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      summarize();
    end
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // request held until pready is sampled high at a rising edge; data taken there
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge pclk);
    req.penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 50);
    rd = rsp.prdata;
    er = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    if (n >= 50) chk(32'h0, 32'h1);
  endtask : apb

  // one sample tick plus flag and pin latency, then optional event clear
  task automatic step(input int t, input int clr, input int a, input int ph);
    @(posedge pclk);
    adc_temp <= t[12:0];
    repeat (SC + 4) @(posedge pclk);
    if (clr != 0) apb(1'b1, `STE_ADDR_STATUS, 32'h1);
    repeat (3) @(posedge pclk);
    chk({30'h0, pout, pin}, {31'h0, (ph != 0) == (a != 0)});
  endtask : step

  task automatic cmd(input ste_op_t op, input logic [1:0] b, input logic h, input logic ok);
    logic rf;
    logic [7:0] off;
    ste_host_model_i.set_pins(sel, h);
    repeat (4) @(posedge pclk);
    apb(1'b1, `STE_ADDR_CMD, {21'h0, b, op, 3'b011, sel[2:1], (sel[0] | h) ^ ~ok, 1'b0});
    ste_host_model_i.frame();
    repeat (8) @(posedge pclk);
    rf = !ok || (op != STE_OP_PAGE && !h);
    if (!rf && op == STE_OP_SET) lk_e[b] = 1'b1;
    if (!rf && op == STE_OP_CLR) lk_e = 4'h0;
    if (!rf && op == STE_OP_PAGE) pg_e = b[0];
    apb(1'b0, `STE_ADDR_PROT, 32'h0);
    chk(rd, {25'h0, rf, 1'b0, pg_e, lk_e});
    chk({27'h0, page_sel, block_lock}, {27'h0, pg_e, lk_e});
    off = 8'(xs());
    apb(1'b1, `STE_ADDR_ACC, {24'h0, off});
    apb(1'b0, `STE_ADDR_ACC, 32'h0);
    chk(rd, {22'h0, lk_e[{pg_e, off[7]}], pg_e, off});
  endtask : cmd

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize

  initial begin
    logic [12:0] v;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({25'h0, oe, pout, page_sel, block_lock}, 32'h0);
    apb(1'b0, `STE_ADDR_PROT, 32'h0);
    chk(rd, 32'h0);
    $display("reset test done");
    for (int i = 0; i < 3; i++) begin
      v = 13'(xs());
      apb(1'b1, `STE_ADDR_HIGH + 8'(4 * i), {19'h7ffff, v});
      apb(1'b0, `STE_ADDR_HIGH + 8'(4 * i), 32'h0);
      chk(rd, {19'h0, v});
    end
    v = 13'(xs());
    apb(1'b1, `STE_ADDR_CFG, {26'h0, v[5:0]});
    apb(1'b0, `STE_ADDR_CFG, 32'h0);
    chk(rd, {26'h0, v[5:0]});
    apb(1'b0, 8'h40, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    $display("limits test done");
    apb(1'b1, `STE_ADDR_CFG, 32'h0);
    repeat (4) begin
      v = 13'(xs());
      @(posedge pclk);
      adc_temp <= v;
      repeat (SC + 2) @(posedge pclk);
      apb(1'b1, `STE_ADDR_TEMP, ~{19'h0, v});
      apb(1'b0, `STE_ADDR_TEMP, 32'h0);
      chk(rd, {19'h0, v});
    end
    $display("temperature test done");
    apb(1'b1, `STE_ADDR_HIGH, 32'd800);
    apb(1'b1, `STE_ADDR_LOW, 32'd200);
    apb(1'b1, `STE_ADDR_CRIT, 32'd1000);
    // comparator, hysteresis 1.5 C
    apb(1'b1, `STE_ADDR_CFG, 32'h19);
    step(500, 0, 0, 0);
    step(801, 0, 1, 0);
    step(790, 0, 1, 0);
    step(776, 0, 0, 0);
    step(199, 0, 1, 0);
    step(224, 0, 0, 0);
    // interrupt, then critical on top of it
    apb(1'b1, `STE_ADDR_CFG, 32'h18);
    step(801, 0, 1, 0);
    step(500, 0, 1, 0);
    step(500, 1, 0, 0);
    step(1001, 0, 1, 0);
    step(1001, 1, 1, 0);
    step(500, 0, 0, 0);
    // critical only, hysteresis 3 C
    apb(1'b1, `STE_ADDR_CFG, 32'h2a);
    step(801, 0, 0, 0);
    step(199, 0, 0, 0);
    step(1001, 0, 1, 0);
    step(952, 0, 1, 0);
    step(951, 0, 0, 0);
    // active high comparator, no hysteresis, then disabled
    apb(1'b1, `STE_ADDR_CFG, 32'h0d);
    step(500, 0, 0, 1);
    step(801, 0, 1, 1);
    step(800, 0, 0, 1);
    apb(1'b1, `STE_ADDR_CFG, 32'h01);
    step(801, 0, 0, 0);
    $display("alert test done");
    sel = 3'(xs());
    cmd(STE_OP_SET, 2'd0, 1'b1, 1'b1);
    cmd(STE_OP_SET, 2'd3, 1'b1, 1'b1);
    cmd(STE_OP_SET, 2'd1, 1'b0, 1'b1);
    cmd(STE_OP_PAGE, 2'd1, 1'b0, 1'b1);
    cmd(STE_OP_SET, 2'd1, 1'b1, 1'b0);
    cmd(STE_OP_SET, 2'd1, 1'b1, 1'b1);
    cmd(STE_OP_SET, 2'd2, 1'b1, 1'b1);
    cmd(STE_OP_CLR, 2'd0, 1'b0, 1'b1);
    cmd(STE_OP_CLR, 2'd0, 1'b1, 1'b1);
    cmd(STE_OP_SET, 2'd2, 1'b1, 1'b1);
    cmd(STE_OP_PAGE, 2'd0, 1'b0, 1'b1);
    cmd(STE_OP_CLR, 2'd3, 1'b1, 1'b0);
    repeat (8) begin
      v = 13'(xs());
      sel = v[12:10];
      cmd(ste_op_t'(v[1:0] == 2'h0 ? 2'h1 : v[1:0]), v[3:2], v[4], v[5] | v[6]);
    end
    $display("protect test done");
    summarize();
  end
endmodule : tb_top
